/* src/sram_host_pkg.sv */
// constants shared by the asynchronous static memory host controller
package sram_host_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 8;
  // device timing, figures in ns
  localparam int T_CYCLE_NS = 55;
  localparam int T_ADDR_DATA_NS = 55;
  localparam int T_GATE_DATA_NS = 25;
  localparam int T_OFF_NS = 20;
  localparam int T_SETUP_DATA_NS = 25;
  localparam int T_HOLD_DATA_NS = 0;
  localparam int T_ADDR_END_NS = 40;
  localparam int T_PULSE_NS = 40;
  // cycle counts: least times round up
  localparam int READ_CYC = (T_ADDR_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int OFF_CYC = (T_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_MIN_CYC = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SD_OFF_CYC = (T_SETUP_DATA_NS + T_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC = (SD_OFF_CYC > PULSE_MIN_CYC) ? SD_OFF_CYC : PULSE_MIN_CYC;
  localparam int HOLD_CYC = (T_HOLD_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int CNT_W = 4;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_DONE = 3'b011,
    ST_WRITE = 3'b010,
    ST_HOLD = 3'b110,
    ST_TURN = 3'b111
  } state_t;
endpackage : sram_host_pkg

/* src/sram_host.sv */
// host controller that drives a 512K x 8 asynchronous static memory
`timescale 1ns/1ps
// How it works
// - write spans select and write strobe low
// - data timed from write strobe rising edge
// - data set up before end, held after
// - address held through whole write pulse
// - address set before start, held past end
// - write pulse covers setup plus turn-off
// - host drives only after device released
// - write strobe high throughout reads
// - address valid before select falls
module sram_host
  import sram_host_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic [DATA_W-1:0] req_wdata_in,
  output logic req_ready_out,
  output logic rd_valid_out,
  output logic [DATA_W-1:0] rd_data_out,
  output logic [ADDR_W-1:0] word_select_lines_out,
  output logic chip_sel_n_out,
  output logic write_n_out,
  output logic gate_n_out,
  input wire logic [DATA_W-1:0] byte_lines_in,
  output logic [DATA_W-1:0] byte_lines_out,
  output logic byte_lines_oe_out
);
  // ****************************************
  // reset and input synchronisers
  // ****************************************
  logic rst_s1_q, rst_n_q;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end
  // read data arrives from an unclocked device
  // two flops cost two cycles of read latency; the read wait is stretched to cover them
  logic [DATA_W-1:0] din_s1_q, din_s2_q;
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      din_s1_q <= DATA_RST;
      din_s2_q <= DATA_RST;
    end else begin
      din_s1_q <= byte_lines_in;
      din_s2_q <= din_s1_q;
    end
  end
  // ****************************************
  // sequencer
  // ****************************************
  state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          cnt_q <= '0;
          // a request is taken on any idle edge; ready is a registered hint one cycle behind
          if (req_valid_in) begin
            state_q <= req_write_in ? ST_WRITE : ST_READ;
          end
        end
        ST_READ: begin
          cnt_q <= cnt_q + 4'h1;
          // two extra cycles let data pass the synchroniser
          if (cnt_q == CNT_W'(READ_CYC + 1)) begin
            state_q <= ST_DONE;
            cnt_q <= '0;
          end
        end
        ST_DONE: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == CNT_W'(OFF_CYC - 1)) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
          end
        end
        ST_WRITE: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == CNT_W'(PULSE_CYC - 1)) begin
            state_q <= ST_HOLD;
            cnt_q <= '0;
          end
        end
        ST_HOLD: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == CNT_W'(HOLD_CYC - 1)) begin
            state_q <= ST_TURN;
            cnt_q <= '0;
          end
        end
        ST_TURN: begin
          state_q <= ST_IDLE;
          cnt_q <= '0;
        end
        default: begin
          state_q <= ST_IDLE;
          cnt_q <= '0;
        end
      endcase
    end
  end
  // ****************************************
  // pin drive
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      word_select_lines_out <= ADDR_RST;
      byte_lines_out <= DATA_RST;
    end else if (state_q == ST_IDLE && req_valid_in) begin
      // address and data latched a cycle before any strobe falls
      word_select_lines_out <= req_addr_in;
      byte_lines_out <= req_wdata_in;
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      chip_sel_n_out <= 1'b1;
      write_n_out <= 1'b1;
      gate_n_out <= 1'b1;
      byte_lines_oe_out <= 1'b0;
    end else begin
      // select stays low one cycle past the write strobe
      chip_sel_n_out <= !(state_q inside {ST_READ, ST_WRITE, ST_HOLD});
      write_n_out <= !(state_q == ST_WRITE);
      gate_n_out <= !(state_q == ST_READ);
      byte_lines_oe_out <= state_q inside {ST_WRITE, ST_HOLD};
    end
  end
  // ****************************************
  // user side
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      req_ready_out <= 1'b0;
      rd_valid_out <= 1'b0;
      rd_data_out <= DATA_RST;
    end else begin
      req_ready_out <= (state_q == ST_IDLE) && !req_valid_in;
      rd_valid_out <= (state_q == ST_READ) && (cnt_q == CNT_W'(READ_CYC + 1));
      if ((state_q == ST_READ) && (cnt_q == CNT_W'(READ_CYC + 1))) begin
        rd_data_out <= din_s2_q;
      end
    end
  end
  // ****************************************
  // checks
  // ****************************************
  // cycles since the select last fell; saturates so a long idle spell never wraps into a short count
  logic sel_prev_n_q;
  logic [CNT_W-1:0] since_sel_q;
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sel_prev_n_q <= 1'b1;
      since_sel_q <= '1;
    end else begin
      sel_prev_n_q <= chip_sel_n_out;
      if (sel_prev_n_q && !chip_sel_n_out) begin
        since_sel_q <= CNT_W'(1);
      end else if (since_sel_q != '1) begin
        since_sel_q <= since_sel_q + CNT_W'(1);
      end
    end
  end
  // ****************************************
  // properties
  // ****************************************
  a_write_no_gate: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    !write_n_out |-> gate_n_out && !chip_sel_n_out && byte_lines_oe_out) else $error("bad write strobes");
  a_write_pulse_len: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    $fell(write_n_out) |-> !write_n_out [*6]) else $error("write pulse short");
  a_sel_after_we: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    $rose(write_n_out) |-> !chip_sel_n_out) else $error("select rose with strobe");
  a_addr_stable_wr: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    !write_n_out |-> $stable(word_select_lines_out)) else $error("address moved in write");
  a_read_we_high: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    !gate_n_out |-> write_n_out && !byte_lines_oe_out) else $error("strobe low in read");
  // three quiet cycles after the gate rises cover the device's turn-off time
  a_turn_off_gap: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    $rose(gate_n_out) |-> !byte_lines_oe_out [*3]) else $error("drive too early");
  a_read_len: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    $fell(gate_n_out) |-> !gate_n_out [*8]) else $error("read too short");
  a_idle_deselect: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    state_q == ST_IDLE |=> chip_sel_n_out) else $error("select low when idle");
  // write data and address stay put from the strobe fall until past the terminating edge
  a_wdata_steady: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    !write_n_out |-> $stable(byte_lines_out) && byte_lines_oe_out) else $error("write data moved");
  a_wdata_hold: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    $rose(write_n_out) |-> byte_lines_oe_out && $stable(byte_lines_out)) else $error("write data not held");
  a_addr_hold_end: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    $rose(write_n_out) |-> $stable(word_select_lines_out)) else $error("address not held");
  a_addr_before_sel: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    $fell(chip_sel_n_out) |-> $stable(word_select_lines_out)) else $error("address late for select");
  a_host_drive_gate: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    byte_lines_oe_out |-> gate_n_out && !chip_sel_n_out) else $error("host drives while gate low");
  a_sel_low_len: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    $fell(chip_sel_n_out) |-> !chip_sel_n_out [*5]) else $error("select pulse short");
  a_cycle_len: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    $fell(chip_sel_n_out) |-> int'(since_sel_q) * CLK_PERIOD_NS >= T_CYCLE_NS) else $error("cycle too short");
endmodule : sram_host

/* verif/sram_model.sv */
// behavioural asynchronous static memory on the far side of the host controller
`timescale 1ns/1ps
module sram_model
  import sram_host_pkg::*;
(
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic cs_n_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic host_oe_in,
  input wire logic slow_in,
  output logic [DATA_W-1:0] rdata_out,
  output logic clash_out
);
  logic [DATA_W-1:0] mem_q [int];
  logic [DATA_W-1:0] last_q = 8'h5a;
  logic drive;
  assign drive = !cs_n_in && !oe_n_in && we_n_in;
  assign clash_out = drive && host_oe_in;
  // the first strobe to rise ends the write and latches the byte
  always @(posedge we_n_in or posedge cs_n_in) begin
    if (!cs_n_in || !we_n_in) mem_q[addr_in] = host_oe_in ? wdata_in : ~wdata_in;
  end
  // slow mode answers near the limits, old data lingers before change
  always @(addr_in or drive) begin
    if (drive) begin
      last_q = mem_q.exists(addr_in) ? mem_q[addr_in] : 8'h00;
      rdata_out <= #(slow_in ? 50 : 10) last_q;
    end else begin
      rdata_out <= #(slow_in ? 15 : 3) ~last_q;
    end
  end
endmodule : sram_model

/* verif/async_sram_bus_timing_tb.sv */
// self-checking bench for the static memory host controller
`timescale 1ns/1ps
module async_sram_bus_timing_tb;
  import sram_host_pkg::*;
  logic clk_in = 0, rstn_in = 0, req_valid_in = 0, req_write_in = 0, slow = 0;
  logic [ADDR_W-1:0] req_addr_in = '0, word_select_lines_out;
  logic [DATA_W-1:0] req_wdata_in = '0, rd_data_out, bus, host_d, dev_d;
  logic req_ready_out, rd_valid_out, chip_sel_n_out, write_n_out, gate_n_out, host_oe, clash;
  logic [DATA_W-1:0] shadow [int];
  logic [31:0] lf = 32'h3dd9;
  int fail_count = 0, comparisons = 0, cyc = 0, we_lo = 0;
  assign bus = host_oe ? host_d : dev_d;
  sram_host uut (.clk_in(clk_in), .rstn_in(rstn_in), .req_valid_in(req_valid_in), .req_write_in(req_write_in),
    .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in), .req_ready_out(req_ready_out),
    .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out), .word_select_lines_out(word_select_lines_out),
    .chip_sel_n_out(chip_sel_n_out), .write_n_out(write_n_out), .gate_n_out(gate_n_out),
    .byte_lines_in(bus), .byte_lines_out(host_d), .byte_lines_oe_out(host_oe));
  sram_model mem (.addr_in(word_select_lines_out), .cs_n_in(chip_sel_n_out), .we_n_in(write_n_out),
    .oe_n_in(gate_n_out), .wdata_in(bus), .host_oe_in(host_oe), .slow_in(slow), .rdata_out(dev_d), .clash_out(clash));
  initial forever #4 clk_in = ~clk_in;
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // ******************************
  // one request, reads checked against the shadow copy
  // ******************************
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    while (req_ready_out !== 1'b1 && n < 40) begin @(negedge clk_in); n++; end
    chk(req_ready_out, 1'b1);
    req_valid_in = 1; req_write_in = wr; req_addr_in = a; req_wdata_in = d;
    @(negedge clk_in);
    req_valid_in = 0;
    if (wr) shadow[a] = d;
    else begin
      n = 0;
      while (rd_valid_out !== 1'b1 && n < 30) begin @(negedge clk_in); n++; end
      chk(rd_valid_out, 1'b1);
      chk(rd_data_out, shadow.exists(a) ? shadow[a] : 8'h00);
    end
  endtask : xfer
  // pin-level watch of every cycle; quiet while reset holds, as pins leaving unknown look like edges
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin fail_count++; final_report; end
    else if (rstn_in) begin
      if (!write_n_out) we_lo <= we_lo + 1;
      if ($rose(write_n_out)) begin chk(we_lo >= PULSE_CYC, 1); we_lo <= 0; end
      if (!chip_sel_n_out && !gate_n_out) chk(write_n_out, 1'b1);
      if ($rose(chip_sel_n_out)) chk($rose(write_n_out), 1'b0);
      if (host_oe) chk({clash, gate_n_out}, 2'b01);
    end
  end
  initial begin
    repeat (16) @(negedge clk_in);
    rstn_in = 1;
    xfer(0, 19'h00000, 0); xfer(1, 19'h00000, 8'ha5); xfer(1, 19'h7ffff, 8'h3c);
    xfer(0, 19'h7ffff, 0); xfer(0, 19'h00000, 0); xfer(1, 19'h00001, 8'hff); xfer(0, 19'h00001, 0);
    $display("corner test done");
    for (int i = 0; i < 60; i++) begin
      if (i == 30) slow = 1;
      lf = nxt(lf);
      xfer(lf[0], {16'h0000, lf[3:1]} ^ {lf[27:9], 3'b000} & 19'h0000f, lf[31:24]);
    end
    $display("random test done");
    final_report;
  end
endmodule : async_sram_bus_timing_tb
